// file: hdl/led_dim_pkg.sv
/*
  Constants, enums and structs of the LED dimming controller. Assumes one
  40 MHz core clock; the 20 MHz oscillator is an enable tick from it.
*/
package led_dim_pkg;

  localparam int CORE_HZ = 40_000_000;
  localparam int OSC_HZ = 20_000_000;
  localparam int OSC_DIV = CORE_HZ / OSC_HZ;
  localparam int OSC_W = $clog2(OSC_DIV);
  localparam int CORE_NS = 1_000_000_000 / CORE_HZ;
  // on-time hysteresis in ns, then core cycles
  localparam int HYST_NS = 6400;
  localparam int HYST_CYC = HYST_NS / CORE_NS;
  localparam int NUM_CH = 4;
  localparam int BRT_W = 16;
  localparam int SCALE_W = 12;
  // longest led pwm period is 2^17 oscillator ticks (152 Hz)
  localparam int CNT_W = 17;
  localparam int MAX_DITH = 4;
  localparam int FREQ_W = 3;
  localparam int SYNC_STAGES = 2;
  localparam logic [SCALE_W-1:0] SCALE_RESET = 12'hFFF;
  localparam logic [BRT_W-1:0] BRT_FULL = 16'hFFFF;
  localparam logic [BRT_W-1:0] HYB_THRESH = 16'h2000;
  localparam int HYB_SHIFT = 3;
  localparam logic [6:0] ADDR_MAIN = 7'h3B;
  localparam logic [6:0] ADDR_ALT = 7'h3A;
  localparam int CYC_PER_MS = CORE_HZ / 1000;
  localparam int SLOPE_W = 16;
  // full-scale sweep time per slope select code, 0 = sloper off
  localparam int SLOPE_MS [8] = '{0, 50, 100, 200, 300, 500, 1000, 2000};

  typedef enum logic [2:0] {CFG_4CH, CFG_3CH, CFG_2CH, CFG_2GRP, CFG_1GRP} string_cfg_e;
  typedef enum logic [1:0] {MODE_PSPWM, MODE_HYBRID, MODE_CURRENT, MODE_DIRECT} dim_mode_e;

  typedef struct packed {
    string_cfg_e string_config_strap;
    logic addr_alt;
    dim_mode_e mode;
    logic [FREQ_W-1:0] led_pwm_freq_strap;
  } strap_s;

  typedef struct packed {
    logic brightness_source_select;
    logic [2:0] slope_select;
    logic [3:0] dither_select;
    logic hybrid_zero;
  } ctrl_s;

  localparam ctrl_s CTRL_RESET = '{
    brightness_source_select: 1'b0,
    slope_select: 3'h3,
    dither_select: 4'h0,
    hybrid_zero: 1'b0
  };

endpackage

// file: hdl/led_string_dimming_control.sv
/*
  Dimming control for four LED sink channels: strap latch, brightness
  source, sloper, dither, phased led pwm and string current. Assumes a
  40 MHz clock, synchronous low reset and straps stable at power-up.
*/
// Operation
// - amplitude is string scale over 4095 of the set maximum.
// - string scales reset to 0xFFF.
// - two to four strings, or two or one ganged group.
// - phase offsets 90, 120, 180 degrees or none.
// - configuration and phases captured once after each reset.
// - led pwm runs from the 20 MHz tick, not the input.
// - eight led pwm frequencies, 152 Hz to 19531 Hz.
// - undithered resolution 16 down to 10 bits.
// - one brightness from pin duty or register.
// - source select resets to the pwm input.
// - sloper on after reset; sloper and dither programmable.
// - mode strap sets dimming mode and address 0x3B or 0x3A.
// - phase-shift mode pulses channels evenly offset.
// - hybrid uses pwm at low, amplitude at high brightness.
// - hybrid threshold 12.5 or 0 percent.
// - direct mode follows the input pwm.
// - on-time changes under 6.4 us leave the duty unchanged.
// - dither off or 1 to 4 bits; resets off.
// - N-bit dither lengthens dither-value pulses per 2^N periods.
// - slope 000 disables sloper; reset gives 200 ms sweep.
`timescale 1ns/1ps
module led_string_dimming_control #(
  parameter int MEAS_W = 24
) (
  input wire logic CORE_CLK, // 40 MHz core clock
  input wire logic RST_N, // synchronous reset, active low
  input wire logic PWM_IN, // brightness pwm pin, asynchronous
  input wire led_dim_pkg::strap_s STRAP_IN, // decoded strap pins
  input wire logic CTRL_WR, // control register load
  input wire led_dim_pkg::ctrl_s CTRL_WDATA, // control write data
  input wire logic [led_dim_pkg::NUM_CH-1:0] SCALE_WR, // per-string scale load
  input wire logic [led_dim_pkg::SCALE_W-1:0] SCALE_WDATA, // scale write data
  input wire logic [led_dim_pkg::BRT_W-1:0] DISPLAY_BRIGHTNESS_VALUE, // brightness reg
  output led_dim_pkg::ctrl_s CTRL_Q, // control register contents
  output logic [led_dim_pkg::NUM_CH*led_dim_pkg::SCALE_W-1:0] SCALE_Q, // scales
  output led_dim_pkg::strap_s STRAP_Q, // latched straps
  output logic CFG_LATCHED, // straps have been captured
  output logic [6:0] I2C_ADDR, // target address from mode strap
  output logic [led_dim_pkg::BRT_W-1:0] BRIGHTNESS_NOW, // sloped brightness
  output logic [led_dim_pkg::NUM_CH-1:0] LED_ON, // channel sink enables
  output logic [led_dim_pkg::NUM_CH*led_dim_pkg::SCALE_W-1:0] LED_CURRENT // amplitudes
);
  import led_dim_pkg::*;

  if (MEAS_W <= BRT_W)
    $error("led_string_dimming_control: MEAS_W too small");

  function automatic logic [NUM_CH-1:0] active_mask(string_cfg_e c);
    case (c)
      CFG_3CH: active_mask = 4'h7;
      CFG_2CH: active_mask = 4'h3;
      default: active_mask = 4'hF;
    endcase
  endfunction

  function automatic logic [CNT_W-1:0] phase_offset(strap_s s, int ch);
    logic [CNT_W+2:0] per;
    logic [2:0] n;
    logic [1:0] slot;
    per = (CNT_W+3)'({CNT_W{1'b1}} >> s.led_pwm_freq_strap) + (CNT_W+3)'(1);
    slot = (s.string_config_strap > CFG_2GRP) ? 2'h0
         : (s.string_config_strap == CFG_2GRP) ? 2'(ch >> 1) : 2'(ch);
    case (s.string_config_strap)
      CFG_4CH: n = 3'h4;
      CFG_3CH: n = 3'h3;
      CFG_2CH, CFG_2GRP: n = 3'h2;
      default: n = 3'h1;
    endcase
    phase_offset = CNT_W'((per * slot) / n);
  endfunction

  ////////////////////////////////////////////////////////////////////////////

  logic pin_meta_reg, pin_sync_reg;
  strap_s strap_meta_reg, strap_sync_reg, strap_reg, strap_next;
  logic [1:0] settle_reg, settle_next;
  logic latched_reg, latched_next, latch_now;
  logic [CNT_W-1:0] offset_reg [NUM_CH], offset_next [NUM_CH];

  always_comb
  begin
    settle_next = settle_reg;
    latched_next = latched_reg;
    strap_next = strap_reg;
    latch_now = 1'b0;
    if (!latched_reg)
    begin
      if (settle_reg == 2'(SYNC_STAGES))
      begin
        // only RST_N low reopens this window
        latch_now = 1'b1;
        latched_next = 1'b1;
        strap_next = strap_sync_reg;
      end
      else
        settle_next = settle_reg + 2'h1;
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      pin_meta_reg <= 1'b0;
      pin_sync_reg <= 1'b0;
      strap_meta_reg <= '0;
      strap_sync_reg <= '0;
      strap_reg <= '0;
      settle_reg <= '0;
      latched_reg <= 1'b0;
      for (int i = 0; i < NUM_CH; i++)
        offset_reg[i] <= '0;
    end
    else
    begin
      pin_meta_reg <= PWM_IN;
      pin_sync_reg <= pin_meta_reg;
      strap_meta_reg <= STRAP_IN;
      strap_sync_reg <= strap_meta_reg;
      strap_reg <= strap_next;
      settle_reg <= settle_next;
      latched_reg <= latched_next;
      for (int i = 0; i < NUM_CH; i++)
        offset_reg[i] <= offset_next[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  ctrl_s ctrl_reg, ctrl_next;
  logic [SCALE_W-1:0] scale_reg [NUM_CH], scale_next [NUM_CH];

  always_comb ctrl_next = CTRL_WR ? CTRL_WDATA : ctrl_reg;

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      ctrl_reg <= CTRL_RESET;
      for (int i = 0; i < NUM_CH; i++)
        scale_reg[i] <= SCALE_RESET;
    end
    else
    begin
      ctrl_reg <= ctrl_next;
      for (int i = 0; i < NUM_CH; i++)
        scale_reg[i] <= scale_next[i];
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  logic [OSC_W-1:0] osc_reg, osc_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next, period_m1;
  logic [MAX_DITH-1:0] pidx_reg, pidx_next;
  logic tick;

  always_comb
  begin
    period_m1 = {CNT_W{1'b1}} >> strap_reg.led_pwm_freq_strap;
    tick = (osc_reg == OSC_W'(OSC_DIV - 1));
    osc_next = tick ? '0 : osc_reg + OSC_W'(1);
    cnt_next = cnt_reg;
    pidx_next = pidx_reg;
    // free running, never resynchronised to the input pwm
    if (tick)
    begin
      if (cnt_reg >= period_m1)
      begin
        cnt_next = '0;
        pidx_next = pidx_reg + MAX_DITH'(1);
      end
      else
        cnt_next = cnt_reg + CNT_W'(1);
    end
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      osc_reg <= '0;
      cnt_reg <= '0;
      pidx_reg <= '0;
    end
    else
    begin
      osc_reg <= osc_next;
      cnt_reg <= cnt_next;
      pidx_reg <= pidx_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  logic [BRT_W-1:0] meter_duty, target, bright_reg, bright_next;
  logic [SLOPE_W-1:0] slope_cnt_reg, slope_cnt_next, slope_step;

  pwm_duty_meter #(.MEAS_W(MEAS_W), .HYST(HYST_CYC)) u_meter (
    .clk(CORE_CLK), .rst_n(RST_N), .pwm_level(pin_sync_reg), .duty(meter_duty));

  always_comb
  begin
    target = ctrl_reg.brightness_source_select ? DISPLAY_BRIGHTNESS_VALUE
                                               : meter_duty;
    slope_step = SLOPE_W'((SLOPE_MS[ctrl_reg.slope_select] * CYC_PER_MS) >> BRT_W);
    slope_cnt_next = slope_cnt_reg;
    bright_next = bright_reg;
    // constant rate: a full-scale move takes the selected time
    if (ctrl_reg.slope_select == 3'h0)
    begin
      bright_next = target;
      slope_cnt_next = '0;
    end
    else if (slope_cnt_reg + SLOPE_W'(1) >= slope_step)
    begin
      slope_cnt_next = '0;
      if (bright_reg < target)
        bright_next = bright_reg + BRT_W'(1);
      else if (bright_reg > target)
        bright_next = bright_reg - BRT_W'(1);
    end
    else
      slope_cnt_next = slope_cnt_reg + SLOPE_W'(1);
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      bright_reg <= '0;
      slope_cnt_reg <= '0;
    end
    else
    begin
      bright_reg <= bright_next;
      slope_cnt_reg <= slope_cnt_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  logic [BRT_W-1:0] pwm_b, amp;
  logic [BRT_W:0] amp_eff;
  logic [BRT_W+MAX_DITH:0] shifted;
  logic [MAX_DITH-1:0] dith_val, dith_mask;
  logic [2:0] dith_n;
  logic [CNT_W:0] on_t;
  logic pwm_full;
  logic [NUM_CH-1:0] active, on_next, on_reg;
  logic [SCALE_W-1:0] cur_reg [NUM_CH], cur_next [NUM_CH];

  always_comb
  begin
    pwm_b = BRT_FULL;
    amp = BRT_FULL;
    case (strap_reg.mode)
      MODE_PSPWM: pwm_b = bright_reg;
      MODE_HYBRID:
      begin
        if (ctrl_reg.hybrid_zero || bright_reg >= HYB_THRESH)
          amp = bright_reg;
        else
        begin
          // below threshold: fixed low amplitude, pwm carries the rest
          pwm_b = bright_reg << HYB_SHIFT;
          amp = HYB_THRESH;
        end
      end
      MODE_CURRENT: amp = bright_reg;
      default: amp = BRT_FULL;
    endcase
    // all-ones maps to 65536 so full scale keeps the string scale
    amp_eff = {1'b0, amp} + (BRT_W+1)'(amp[BRT_W-1]);
    pwm_full = (pwm_b == BRT_FULL);
    shifted = {pwm_b, {(MAX_DITH+1){1'b0}}} >> strap_reg.led_pwm_freq_strap;
    dith_n = (ctrl_reg.dither_select > 4'(MAX_DITH)) ? 3'(MAX_DITH)
                                                     : ctrl_reg.dither_select[2:0];
    dith_val = shifted[MAX_DITH-1:0] >> (3'(MAX_DITH) - dith_n);
    dith_mask = {MAX_DITH{1'b1}} >> (3'(MAX_DITH) - dith_n);
    on_t = {1'b0, shifted[BRT_W+MAX_DITH:MAX_DITH]}
         + (CNT_W+1)'(dith_val > (pidx_reg & dith_mask));
    active = active_mask(strap_reg.string_config_strap);
  end

  for (genvar i = 0; i < NUM_CH; i++)
  begin : g_ch
    logic [CNT_W:0] sum;
    logic [CNT_W-1:0] phase;
    logic [SCALE_W+BRT_W:0] prod;
    logic hit;
    assign sum = {1'b0, cnt_reg} + {1'b0, offset_reg[i]};
    assign phase = (sum > {1'b0, period_m1}) ? CNT_W'(sum - {1'b0, period_m1} - 1'b1)
                                             : sum[CNT_W-1:0];
    assign hit = pwm_full || ({1'b0, phase} < on_t);
    assign prod = scale_reg[i] * amp_eff;
    assign scale_next[i] = SCALE_WR[i] ? SCALE_WDATA : scale_reg[i];
    assign offset_next[i] = latch_now ? phase_offset(strap_sync_reg, i)
                                      : offset_reg[i];
    assign on_next[i] = active[i] && ((strap_reg.mode == MODE_DIRECT) ? pin_sync_reg
                      : (strap_reg.mode == MODE_CURRENT) || hit);
    assign cur_next[i] = active[i] ? prod[BRT_W +: SCALE_W] : '0;
    assign SCALE_Q[i*SCALE_W +: SCALE_W] = scale_reg[i];
    assign LED_CURRENT[i*SCALE_W +: SCALE_W] = cur_reg[i];
  end

  always_ff @(posedge CORE_CLK)
  begin
    if (!RST_N)
    begin
      on_reg <= '0;
      for (int i = 0; i < NUM_CH; i++)
        cur_reg[i] <= '0;
    end
    else
    begin
      on_reg <= latched_reg ? on_next : '0;
      for (int i = 0; i < NUM_CH; i++)
        cur_reg[i] <= latched_reg ? cur_next[i] : '0;
    end
  end

  assign LED_ON = on_reg;
  assign CTRL_Q = ctrl_reg;
  assign STRAP_Q = strap_reg;
  assign CFG_LATCHED = latched_reg;
  assign I2C_ADDR = strap_reg.addr_alt ? ADDR_ALT : ADDR_MAIN;
  assign BRIGHTNESS_NOW = bright_reg;

endmodule

// file: hdl/pwm_duty_meter.sv
/*
  Duty meter for the pwm input: 16-bit fraction, on-time hysteresis,
  serial divider. Assumes an input already synchronised to this clock.
*/
`timescale 1ns/1ps
module pwm_duty_meter #(
  parameter int MEAS_W = 24,
  parameter int HYST = led_dim_pkg::HYST_CYC
) (
  input wire logic clk, // core clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic pwm_level, // synchronised pwm input
  output logic [led_dim_pkg::BRT_W-1:0] duty // measured duty, full scale = all ones
);
  import led_dim_pkg::*;

  if (MEAS_W <= BRT_W)
    $error("pwm_duty_meter: MEAS_W must exceed the duty width");

  logic prev_reg, prev_next;
  logic busy_reg, busy_next;
  logic [MEAS_W-1:0] hi_reg, hi_next, per_reg, per_next;
  logic [MEAS_W-1:0] held_reg, held_next, den_reg, den_next;
  logic [MEAS_W:0] rem_reg, rem_next;
  logic [BRT_W-1:0] quo_reg, quo_next, duty_reg, duty_next;
  logic [4:0] bits_reg, bits_next;

  always_comb
  begin
    logic [MEAS_W:0] rem2;
    logic [MEAS_W-1:0] diff, new_hi;
    rem2 = '0;
    diff = '0;
    new_hi = '0;
    prev_next = pwm_level;
    busy_next = busy_reg;
    hi_next = hi_reg;
    per_next = per_reg;
    held_next = held_reg;
    den_next = den_reg;
    rem_next = rem_reg;
    quo_next = quo_reg;
    duty_next = duty_reg;
    bits_next = bits_reg;
    if (pwm_level && !prev_reg)
    begin
      per_next = MEAS_W'(1);
      hi_next = MEAS_W'(1);
      diff = (hi_reg > held_reg) ? hi_reg - held_reg : held_reg - hi_reg;
      // small on-time wobble from slow edges must not move the duty
      new_hi = (diff > MEAS_W'(HYST)) ? hi_reg : held_reg;
      held_next = new_hi;
      if (!busy_reg)
      begin
        if (new_hi >= per_reg)
          duty_next = BRT_FULL;
        else
        begin
          den_next = per_reg;
          rem_next = {1'b0, new_hi};
          quo_next = '0;
          bits_next = 5'(BRT_W);
          busy_next = 1'b1;
        end
      end
    end
    else
    begin
      if (per_reg != '1)
        per_next = per_reg + MEAS_W'(1);
      if (pwm_level && hi_reg != '1)
        hi_next = hi_reg + MEAS_W'(1);
      // no edge for a whole count range: pin is parked
      if (per_reg == '1 && !busy_reg)
        duty_next = pwm_level ? BRT_FULL : '0;
    end
    if (busy_reg)
    begin
      rem2 = {rem_reg[MEAS_W-1:0], 1'b0};
      if (rem2 >= {1'b0, den_reg})
      begin
        rem_next = rem2 - {1'b0, den_reg};
        quo_next = {quo_reg[BRT_W-2:0], 1'b1};
      end
      else
      begin
        rem_next = rem2;
        quo_next = {quo_reg[BRT_W-2:0], 1'b0};
      end
      bits_next = bits_reg - 5'h01;
      if (bits_reg == 5'h01)
      begin
        busy_next = 1'b0;
        duty_next = quo_next;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      prev_reg <= 1'b0;
      busy_reg <= 1'b0;
      hi_reg <= '0;
      per_reg <= '0;
      held_reg <= '0;
      den_reg <= '0;
      rem_reg <= '0;
      quo_reg <= '0;
      duty_reg <= '0;
      bits_reg <= '0;
    end
    else
    begin
      prev_reg <= prev_next;
      busy_reg <= busy_next;
      hi_reg <= hi_next;
      per_reg <= per_next;
      held_reg <= held_next;
      den_reg <= den_next;
      rem_reg <= rem_next;
      quo_reg <= quo_next;
      duty_reg <= duty_next;
      bits_reg <= bits_next;
    end
  end

  assign duty = duty_reg;

endmodule

// file: sim/led_dim_checker.sv
/*
  Port assertions for the LED dimming controller.
  Assumes one clock and a synchronous low reset; bound below.
*/
`timescale 1ns/1ps
module led_dim_checker
  import led_dim_pkg::*;
(
  input wire logic CORE_CLK, // core clock
  input wire logic RST_N, // reset, active low
  input wire logic PWM_IN, // pwm pin
  input wire logic CTRL_WR, // control load
  input wire ctrl_s CTRL_WDATA, // control data
  input wire logic [3:0] SCALE_WR, // scale loads
  input wire logic [11:0] SCALE_WDATA, // scale data
  input wire logic [15:0] DISPLAY_BRIGHTNESS_VALUE, // brightness register
  input wire ctrl_s CTRL_Q, // control register
  input wire logic [47:0] SCALE_Q, // string scales
  input wire strap_s STRAP_Q, // latched straps
  input wire logic CFG_LATCHED, // straps captured
  input wire logic [6:0] I2C_ADDR, // target address
  input wire logic [15:0] BRIGHTNESS_NOW, // sloped brightness
  input wire logic [3:0] LED_ON, // sink enables
  input wire logic [47:0] LED_CURRENT // amplitudes
);
  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RST_N);

  ////////////////////////////////////////////////////////////////////////////////
  sequence s_capture;
    ##[2:4] CFG_LATCHED;
  endsequence

  a_cfg_capture: assert property ($rose(RST_N) |-> s_capture)
    else $error("straps not captured");
  a_strap_frozen: assert property (CFG_LATCHED |=> CFG_LATCHED && STRAP_Q == $past(STRAP_Q))
    else $error("latched straps moved");
  a_addr_decode: assert property (I2C_ADDR == (STRAP_Q.addr_alt ? 7'h3A : 7'h3B))
    else $error("address mismatch");
  // reset checks run during reset
  a_scale_reset: assert property (disable iff (1'b0) !RST_N |=> SCALE_Q == {4{12'hFFF}})
    else $error("scale reset wrong");
  a_ctrl_reset: assert property (disable iff (1'b0) !RST_N |=> CTRL_Q == CTRL_RESET)
    else $error("control reset wrong");
  a_scale_write: assert property (SCALE_WR[2] |=> SCALE_Q[35:24] == $past(SCALE_WDATA))
    else $error("scale write lost");
  a_ctrl_write: assert property (CTRL_WR |=> CTRL_Q == $past(CTRL_WDATA))
    else $error("control write lost");
  a_slope_off: assert property (CFG_LATCHED && CTRL_Q.slope_select == 3'h0
    && CTRL_Q.brightness_source_select |=> BRIGHTNESS_NOW == $past(DISPLAY_BRIGHTNESS_VALUE))
    else $error("brightness not followed");
  a_slope_step: assert property (CTRL_Q.slope_select == 3'h3
    |=> 16'(BRIGHTNESS_NOW - $past(BRIGHTNESS_NOW)) inside {16'h0000, 16'h0001, 16'hFFFF})
    else $error("sloper step too big");
  a_direct_follow: assert property (STRAP_Q.mode == MODE_DIRECT && $past(CFG_LATCHED, 3)
    && STRAP_Q.string_config_strap == CFG_4CH |-> LED_ON == {4{$past(PWM_IN, 3)}})
    else $error("direct pin not followed");
  a_current_on: assert property (CFG_LATCHED && STRAP_Q.mode == MODE_CURRENT
    && STRAP_Q.string_config_strap == CFG_3CH |=> LED_ON == 4'h7)
    else $error("current channels off");
  a_idle_dark: assert property (CFG_LATCHED && STRAP_Q.string_config_strap == CFG_2CH
    |-> LED_ON[3:2] == 2'h0 && LED_CURRENT[47:24] == 24'h000000)
    else $error("unused channel active");
endmodule

bind led_string_dimming_control led_dim_checker u_checker (
  .CORE_CLK(CORE_CLK), .RST_N(RST_N), .PWM_IN(PWM_IN), .CTRL_WR(CTRL_WR),
  .CTRL_WDATA(CTRL_WDATA), .SCALE_WR(SCALE_WR), .SCALE_WDATA(SCALE_WDATA),
  .DISPLAY_BRIGHTNESS_VALUE(DISPLAY_BRIGHTNESS_VALUE), .CTRL_Q(CTRL_Q), .SCALE_Q(SCALE_Q),
  .STRAP_Q(STRAP_Q), .CFG_LATCHED(CFG_LATCHED), .I2C_ADDR(I2C_ADDR),
  .BRIGHTNESS_NOW(BRIGHTNESS_NOW), .LED_ON(LED_ON), .LED_CURRENT(LED_CURRENT));

// file: sim/led_string_dimming_control_test.sv
/*
  Bench: straps, each dimming mode, sloper and duty hysteresis.
  Assumes the bound checker.
*/
`timescale 1ns/1ps
module led_string_dimming_control_test;
  import led_dim_pkg::*;
  typedef struct {int due; int kind; logic [47:0] exp;} note_s;
  localparam int K_CTRL = 0, K_SCALE = 1, K_STRAP = 2, K_ADDR = 3, K_BRT = 4, K_ON = 5;
  localparam int K_CUR = 6, K_MEAS = 7;
  localparam int OFFS [5][4] = '{'{0, 512, 1024, 1536}, '{0, 682, 1364, 0}, '{0, 1024, 0, 0},
    '{0, 0, 1024, 1024}, '{0, 0, 0, 0}};
  localparam logic [15:0] HB [3] = '{16'h1000, 16'h8000, 16'h1000};
  localparam logic [11:0] HC [3] = '{12'h1FF, 12'h7FF, 12'h0FF};
  logic clk = 1'b0, rst_n = 1'b0, ctrl_wr = 1'b0, pwm_en = 1'b0, pwm_pin, latched;
  logic [23:0] pwm_hi = 24'h0, pwm_per = 24'h1;
  strap_s strap = '0, strap_q;
  ctrl_s wdata = '0, ctrl_q;
  logic [3:0] scale_wr = 4'h0, led_on;
  logic [11:0] scale_wd = 12'h000;
  logic [15:0] brt = 16'h0000, brt_now;
  logic [47:0] scale_q, led_cur;
  logic [6:0] addr;
  logic [31:0] seed = 32'hACA90B87;
  int cycle = 0, fail_count = 0, cmp_count = 0, meas = 0;
  int on_cnt [4], rise [4];
  note_s q [$];

  initial forever #12.5 clk = ~clk;

  led_string_dimming_control dut (
    .CORE_CLK(clk), .RST_N(rst_n), .PWM_IN(pwm_pin), .STRAP_IN(strap), .CTRL_WR(ctrl_wr),
    .CTRL_WDATA(wdata), .SCALE_WR(scale_wr), .SCALE_WDATA(scale_wd),
    .DISPLAY_BRIGHTNESS_VALUE(brt), .CTRL_Q(ctrl_q), .SCALE_Q(scale_q), .STRAP_Q(strap_q),
    .CFG_LATCHED(latched), .I2C_ADDR(addr), .BRIGHTNESS_NOW(brt_now), .LED_ON(led_on),
    .LED_CURRENT(led_cur));
  pwm_source_model u_src (.clk(clk), .en(pwm_en), .hi_cyc(pwm_hi), .per_cyc(pwm_per),
    .pin(pwm_pin));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input int kind, input logic [47:0] got, input logic [47:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t kind %0d got %h exp %h", $time, kind, got, exp);
    end
  endtask

  function automatic logic [47:0] got_of(input int kind);
    case (kind)
      K_CTRL: return 48'(ctrl_q);
      K_SCALE: return scale_q;
      K_STRAP: return 48'(strap_q);
      K_ADDR: return 48'(addr);
      K_BRT: return 48'(brt_now);
      K_ON: return 48'(led_on);
      K_CUR: return led_cur;
      default: return 48'(meas);
    endcase
  endfunction

  // watcher: a note is compared when its due cycle arrives
  always @(posedge clk)
  begin
    cycle <= cycle + 1;
    while (q.size() > 0 && q[0].due <= cycle)
    begin
      check(q[0].kind, got_of(q[0].kind), q[0].exp);
      void'(q.pop_front());
    end
    if (cycle == 60000)
    begin
      fail_count++;
      stop_test;
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  function automatic logic [47:0] curv(input logic [3:0] act, input logic [47:0] sc,
    input logic [15:0] b);
    for (int i = 0; i < 4; i++)
      curv[12*i +: 12] = act[i] ? 12'((29'(sc[12*i +: 12]) * (29'(b) + b[15])) >> 16) : 12'h000;
  endfunction

  task automatic expect_at(input int kind, input logic [47:0] exp, input int w);
    q.push_back('{cycle + w, kind, exp});
    repeat (w + 1) @(posedge clk);
  endtask

  task automatic mexp(input int got, input int exp);
    meas = got;
    expect_at(K_MEAS, 48'(exp), 1);
  endtask

  task automatic do_reset(input strap_s s);
    @(posedge clk);
    strap <= s;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  task automatic wctrl(input logic src, input logic [2:0] sl, input logic [3:0] di, input logic hz);
    ctrl_wr <= 1'b1;
    wdata <= '{src, sl, di, hz};
    @(posedge clk);
    ctrl_wr <= 1'b0;
    expect_at(K_CTRL, 48'({src, sl, di, hz}), 1);
  endtask

  // on-cycles and first rise per channel
  task automatic measure(input int n);
    logic [3:0] prev;
    prev = led_on;
    on_cnt = '{4{0}};
    rise = '{4{-1}};
    repeat (n)
    begin
      @(posedge clk);
      for (int i = 0; i < 4; i++)
      begin
        on_cnt[i] += led_on[i];
        if (led_on[i] && !prev[i] && rise[i] < 0)
          rise[i] = cycle;
      end
      prev = led_on;
    end
  endtask

  task automatic wait_brt(input logic [15:0] v);
    for (int i = 0; i < 400 && brt_now !== v; i++)
      @(posedge clk);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    strap_s s;
    logic [3:0] act;
    logic [47:0] sc;
    logic [15:0] b;
    int r;
    for (int m = 0; m < 4; m++)
      for (int c = 0; c < 5; c++)
      begin
        s = '{string_cfg_e'(c), c[0], dim_mode_e'(m), 3'h7};
        act = (c == 1) ? 4'h7 : (c == 2) ? 4'h3 : 4'hF;
        do_reset(s);
        if (m == 0 && c == 0)
        begin
          expect_at(K_CTRL, 48'({1'b0, 3'h3, 4'h0, 1'b0}), 1);
          expect_at(K_SCALE, {4{12'hFFF}}, 1);
        end
        expect_at(K_ADDR, c[0] ? 48'h3A : 48'h3B, 1);
        strap <= strap_s'(~s);
        expect_at(K_STRAP, 48'(s), 4);
        if (m == 0)
        begin
          wctrl(1'b1, 3'h0, 4'h0, 1'b0);
          brt <= 16'h8040;
          expect_at(K_CUR, curv(act, {4{12'hFFF}}, 16'hFFFF), 12);
          measure(2048);
          for (int i = 0; i < 4; i++)
          begin
            mexp(on_cnt[i], act[i] ? 1026 : 0);
            if (act[i])
              mexp((rise[0] - rise[i] + 2048) % 2048, OFFS[c][i]);
          end
          if (c == 0)
          begin
            r = rise[0];
            measure(2048);
            mexp(rise[0] - r, 2048);
            wctrl(1'b1, 3'h0, 4'h1, 1'b0);
            brt <= 16'h8020;
            measure(2100);
            measure(4096);
            mexp(on_cnt[0], 2050);
          end
        end
        if (m == 1 && c == 0)
          for (int k = 0; k < 3; k++)
          begin
            wctrl(1'b1, 3'h0, 4'h0, k == 2);
            brt <= HB[k];
            expect_at(K_CUR, {4{HC[k]}}, 8);
          end
        if (m == 2)
        begin
          wctrl(1'b1, 3'h0, 4'h0, 1'b0);
          b = 16'(rnd());
          brt <= b;
          for (int i = 0; i < 4; i++)
          begin
            sc[12*i +: 12] = 12'(rnd());
            scale_wr <= 4'(1 << i);
            scale_wd <= sc[12*i +: 12];
            @(posedge clk);
          end
          scale_wr <= 4'h0;
          expect_at(K_SCALE, sc, 2);
          expect_at(K_ON, 48'(act), 4);
          expect_at(K_CUR, curv(act, sc, b), 1);
        end
        if (m == 3)
        begin
          pwm_per <= 24'h28;
          pwm_hi <= 24'hD;
          pwm_en <= 1'b1;
          repeat (200) @(posedge clk);
          pwm_hi <= 24'h28;
          expect_at(K_ON, 48'(act), 90);
          pwm_en <= 1'b0;
          expect_at(K_ON, 48'h0, 8);
        end
        $display("strap test mode %0d config %0d done", m, c);
      end
    do_reset('{CFG_4CH, 1'b0, MODE_PSPWM, 3'h7});
    wctrl(1'b1, 3'h3, 4'h0, 1'b0);
    brt <= 16'h0005;
    wait_brt(16'h0001);
    r = cycle;
    wait_brt(16'h0002);
    mexp(cycle - r, 122);
    $display("sloper test done");
    wctrl(1'b0, 3'h0, 4'h0, 1'b0);
    pwm_per <= 24'h7D0;
    pwm_hi <= 24'h3E8;
    pwm_en <= 1'b1;
    expect_at(K_BRT, 48'h8000, 6000);
    pwm_hi <= 24'h4B0;
    expect_at(K_BRT, 48'h8000, 6000);
    pwm_hi <= 24'h514;
    expect_at(K_BRT, 48'hA666, 6000);
    $display("duty hysteresis test done");
    stop_test;
  end
endmodule

// file: sim/pwm_source_model.sv
/*
  Host pwm source driving the controller's brightness pin.
  Assumes settings change by non-blocking assignment at a clock edge.
*/
`timescale 1ns/1ps
module pwm_source_model (
  input wire logic clk, // bench clock
  input wire logic en, // produce pwm frames
  input wire logic [23:0] hi_cyc, // high time in clocks
  input wire logic [23:0] per_cyc, // period in clocks
  output logic pin // pwm pin
);
  int cnt = 0;
  int hi = 0;
  int per = 1;
  initial pin = 1'b0;
  // settings are taken at frame start only, so no runt pulse appears
  always @(posedge clk)
  begin
    if (!en)
    begin
      cnt <= 0;
      pin <= 1'b0; // idle pin is pulled low
    end
    else
    begin
      if (cnt == 0)
      begin
        hi <= hi_cyc;
        per <= per_cyc;
      end
      pin <= (cnt == 0) ? (hi_cyc > 0) : (cnt < hi);
      cnt <= (cnt + 1 >= ((cnt == 0) ? per_cyc : per)) ? 0 : cnt + 1;
    end
  end
endmodule
